// file: core/pll_seq_pkg.sv
// What this block does
// - In cascade with loop one upstream, hold oscillator one centred until loop two locks, then lock loop one.
// - A digital loop starts only after its reference stays valid for a minimum interval.
// - The phase comparator produces a correction word from feedback minus reference phase.
// - The first correction word cancels the phase error directly, bypassing the filter.
// - Later words pass the loop filter, whose output updates the feedback numerator.
// - A cascaded analog loop takes its reference from the source oscillator divider.
// - Digital loop two lock ignores any offset inherited from analog loop one.
// - Either analog loop may be the upstream source in a cascade.
// - A downstream loop uses its digital loop or runs with it bypassed and powered down.
// - With digital loop two off, oscillator two follows the oscillator one domain.
// - In analog-only mode the digital loops have no influence on the analog loops.
// - After reset, outside cascade, the analog loops lock in order of their start priority settings; in cascade the downstream loop leads.
// - Uncascaded analog loop two locks to the oscillator input independently.
// - Denominator select 0 gives 24-bit programmable, 1 gives fixed 40-bit.
// - A non-cascaded analog loop uses the reference oscillator input as its reference.
// - Each analog loop has a separately enabled doubler on the oscillator path.
// - The buffer configuration code selects termination and bias as tabulated.
// - The buffered oscillator input also feeds the input monitoring logic.
`default_nettype none
package pll_seq_pkg;
    // Register offsets of the control port.
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_FILT1 = 4'h2;
    localparam logic [3:0] ADDR_FILT2 = 4'h3;
    localparam logic [3:0] ADDR_NUM1 = 4'h4;
    localparam logic [3:0] ADDR_NUM2 = 4'h5;
    localparam logic [3:0] ADDR_BUF = 4'h6;
    // Control register field positions.
    localparam int CTRL_ALOOP1_ON = 0;
    localparam int CTRL_ALOOP2_ON = 1;
    localparam int CTRL_DLOOP1_ON = 2;
    localparam int CTRL_DLOOP2_ON = 3;
    localparam int CTRL_CASCADE = 4;
    localparam int CTRL_UPSTREAM2 = 5;
    localparam int CTRL_ORDER1 = 6;
    localparam int CTRL_ORDER2 = 7;
    localparam int CTRL_DENOM1 = 8;
    localparam int CTRL_DENOM2 = 9;
    localparam int CTRL_DBL1 = 10;
    localparam int CTRL_DBL2 = 11;
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam logic [7:0] BUF_RESET = 8'h00;
    // Buffer configuration codes.
    localparam logic [7:0] BUF_NONE = 8'h00;
    localparam logic [7:0] BUF_BIAS = 8'h01;
    localparam logic [7:0] BUF_T100_BIAS = 8'h03;
    localparam logic [7:0] BUF_T50 = 8'h04;
    localparam logic [7:0] BUF_T50_BIAS = 8'h05;
    localparam logic [7:0] BUF_CMOS = 8'h08;
    localparam logic [7:0] BUF_CMOS_T50 = 8'h0c;
    // Timing: reference validation interval and the analog settle time.
    localparam int CLK_MHZ = 100;
    localparam int VALID_US = 10;
    localparam int VALID_CYC = VALID_US * CLK_MHZ;
    localparam int SETTLE_US = 2;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam logic [23:0] CENTRE_NUM = 24'h800000;
    localparam int FILT_SHIFT = 3;

    typedef enum {A_OFF, A_CENTRE, A_WAIT_UP, A_ACQ, A_LOCK} aloop_e;
    typedef enum {D_OFF, D_QUAL, D_FIRST, D_TRACK, D_LOCK} dloop_e;

    // Decoded buffer switches.
    typedef struct packed {
        logic single_ended;
        logic term50;
        logic term100;
        logic bias;
    } buf_sw_s;

    // Per-loop state record.
    typedef struct packed {
        aloop_e a_st;
        dloop_e d_st;
        logic [15:0] cnt;
        logic [15:0] vcnt;
        logic [23:0] num;
        logic signed [15:0] integ;
    } loop_s;

    function automatic buf_sw_s decode_buf(input logic [7:0] code);
        buf_sw_s s;
        s = '0;
        if (code == BUF_BIAS) begin
            s.bias = 1'b1;
        end else if (code == BUF_T100_BIAS) begin
            s.term100 = 1'b1;
            s.bias = 1'b1;
        end else if (code == BUF_T50) begin
            s.term50 = 1'b1;
        end else if (code == BUF_T50_BIAS) begin
            s.term50 = 1'b1;
            s.bias = 1'b1;
        end else if (code == BUF_CMOS) begin
            s.single_ended = 1'b1;
        end else if (code == BUF_CMOS_T50) begin
            s.single_ended = 1'b1;
            s.term50 = 1'b1;
        end
        return s;
    endfunction
endpackage
`default_nettype wire

// file: core/pll_cascade_startup_control.sv
// Our own choices: the register addresses and strobed register access.
`default_nettype none
module pll_cascade_startup_control (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic ref1_valid_pin,
    input wire logic ref2_valid_pin,
    input wire logic ref_osc_present_pin,
    input wire logic signed [15:0] phase_err1,
    input wire logic signed [15:0] phase_err2,
    input wire logic phase_stb1,
    input wire logic phase_stb2,
    output logic [23:0] feedback_num1,
    output logic [23:0] feedback_num2,
    output logic denominator_select1,
    output logic denominator_select2,
    output logic ref_from_cascade1,
    output logic ref_from_cascade2,
    output logic doubler_on1,
    output logic doubler_on2,
    output logic digital_loop_power1,
    output logic digital_loop_power2,
    output logic [3:0] osc_buffer_switches,
    output logic osc_monitor_clk_en
);
    // Whole block state.
    typedef struct packed {
        logic [11:0] ctrl;
        logic [7:0] bufc;
        logic [1:0] syn1;
        logic [1:0] syn2;
        logic [1:0] syn3;
        pll_seq_pkg::loop_s l1;
        pll_seq_pkg::loop_s l2;
        logic [1:0] ph_rise;
        logic [31:0] rdata;
    } state_s;

    state_s s;
    state_s next_s;

    logic r1v;
    logic r2v;
    logic osc_ok;
    assign r1v = s.syn1[1];
    assign r2v = s.syn2[1];
    assign osc_ok = s.syn3[1];

    // One sequencing step of an analog loop; wait_up is high when it must wait for the other loop to lock.
    function automatic pll_seq_pkg::loop_s step_analog(
        input pll_seq_pkg::loop_s l, input logic on, input logic wait_up,
        input logic up_locked, input logic osc);
        pll_seq_pkg::loop_s n;
        n = l;
        if (!on) begin
            n.a_st = pll_seq_pkg::A_OFF;
            n.num = pll_seq_pkg::CENTRE_NUM;
        end else begin
            case (l.a_st)
                pll_seq_pkg::A_OFF: begin
                    n.a_st = pll_seq_pkg::A_CENTRE;
                    n.num = pll_seq_pkg::CENTRE_NUM;
                    n.cnt = '0;
                end
                pll_seq_pkg::A_CENTRE: begin
                    // Oscillator held near centre until the other loop is done.
                    n.a_st = wait_up ? pll_seq_pkg::A_WAIT_UP : pll_seq_pkg::A_ACQ;
                end
                pll_seq_pkg::A_WAIT_UP: begin
                    if (up_locked) begin
                        n.a_st = pll_seq_pkg::A_ACQ;
                    end
                end
                pll_seq_pkg::A_ACQ: begin
                    // Settling needs a live reference, so no oscillator means no progress.
                    if (osc) begin
                        n.cnt = l.cnt + 16'h0001;
                        if (l.cnt == 16'(pll_seq_pkg::SETTLE_CYC - 1)) begin
                            n.a_st = pll_seq_pkg::A_LOCK;
                        end
                    end
                end
                default: begin
                    n.a_st = pll_seq_pkg::A_LOCK;
                end
            endcase
        end
        return n;
    endfunction

    // One step of a digital loop wrapped around its analog loop.
    function automatic pll_seq_pkg::loop_s step_digital(
        input pll_seq_pkg::loop_s l, input logic on, input logic ref_ok,
        input logic a_locked, input logic stb, input logic signed [15:0] err);
        pll_seq_pkg::loop_s n;
        logic signed [15:0] step;
        n = l;
        step = '0;
        if (!on || !a_locked) begin
            n.d_st = on ? pll_seq_pkg::D_QUAL : pll_seq_pkg::D_OFF;
            n.vcnt = '0;
            n.integ = '0;
        end else begin
            case (l.d_st)
                pll_seq_pkg::D_OFF: begin
                    n.d_st = pll_seq_pkg::D_QUAL;
                    n.vcnt = '0;
                end
                pll_seq_pkg::D_QUAL: begin
                    // Reference must stay valid for the whole interval.
                    if (!ref_ok) begin
                        n.vcnt = '0;
                    end else if (l.vcnt == 16'(pll_seq_pkg::VALID_CYC - 1)) begin
                        n.d_st = pll_seq_pkg::D_FIRST;
                    end else begin
                        n.vcnt = l.vcnt + 16'h0001;
                    end
                end
                pll_seq_pkg::D_FIRST: begin
                    // The first word cancels the error outright.
                    if (stb) begin
                        n.num = l.num - 24'(err);
                        n.d_st = pll_seq_pkg::D_TRACK;
                        n.vcnt = '0;
                    end
                end
                default: begin
                    if (!ref_ok) begin
                        n.d_st = pll_seq_pkg::D_QUAL;
                        n.vcnt = '0;
                    end else if (stb) begin
                        // Proportional plus integral filter steers the numerator.
                        n.integ = l.integ + (err >>> pll_seq_pkg::FILT_SHIFT);
                        step = (err >>> 1) + n.integ;
                        n.num = l.num - 24'(step);
                        // Lock judged on own phase error only, so inherited offset is invisible.
                        if (err < 16'sd8 && err > -16'sd8) begin
                            n.d_st = pll_seq_pkg::D_LOCK;
                        end else begin
                            n.d_st = pll_seq_pkg::D_TRACK;
                        end
                    end
                end
            endcase
        end
        return n;
    endfunction

    // Next-state logic: register port, synchronisers and both loops.
    always_comb begin
        logic cas;
        logic up2;
        logic a1_lk;
        logic a2_lk;
        logic d1_on;
        logic d2_on;
        logic [1:0] lk;
        next_s = s;
        next_s.syn1 = {s.syn1[0], ref1_valid_pin};
        next_s.syn2 = {s.syn2[0], ref2_valid_pin};
        next_s.syn3 = {s.syn3[0], ref_osc_present_pin};
        cas = s.ctrl[pll_seq_pkg::CTRL_CASCADE];
        up2 = s.ctrl[pll_seq_pkg::CTRL_UPSTREAM2];
        a1_lk = s.l1.a_st == pll_seq_pkg::A_LOCK;
        a2_lk = s.l2.a_st == pll_seq_pkg::A_LOCK;
        // Digital loops off leaves the analog loops untouched.
        d1_on = s.ctrl[pll_seq_pkg::CTRL_DLOOP1_ON];
        d2_on = s.ctrl[pll_seq_pkg::CTRL_DLOOP2_ON];
        // Start order: cascade makes the downstream loop lead; otherwise the order bits.
        lk = {a2_lk, a1_lk};
        next_s.l1 = step_analog(s.l1, s.ctrl[pll_seq_pkg::CTRL_ALOOP1_ON],
            cas ? !up2 : (s.ctrl[pll_seq_pkg::CTRL_ORDER1] && s.ctrl[pll_seq_pkg::CTRL_ALOOP2_ON]),
            lk[1], osc_ok);
        next_s.l2 = step_analog(s.l2, s.ctrl[pll_seq_pkg::CTRL_ALOOP2_ON],
            cas ? up2 : (s.ctrl[pll_seq_pkg::CTRL_ORDER2] && s.ctrl[pll_seq_pkg::CTRL_ALOOP1_ON]),
            lk[0], osc_ok);
        next_s.l1 = step_digital(next_s.l1, d1_on, r1v, a1_lk, phase_stb1, phase_err1);
        next_s.l2 = step_digital(next_s.l2, d2_on, r2v, a2_lk, phase_stb2, phase_err2);
        // Register access; read data valid for the cycle after the strobe.
        next_s.rdata = '0;
        if (wr) begin
            if (addr == pll_seq_pkg::ADDR_CTRL) begin
                next_s.ctrl = wdata[11:0];
            end else if (addr == pll_seq_pkg::ADDR_BUF) begin
                next_s.bufc = wdata[7:0];
            end
        end
        if (rd) begin
            if (addr == pll_seq_pkg::ADDR_CTRL) begin
                next_s.rdata = {20'h00000, s.ctrl};
            end else if (addr == pll_seq_pkg::ADDR_STATUS) begin
                // Per-loop lock flags for host sequencing.
                next_s.rdata = {26'h0000000, osc_ok,
                    s.l2.d_st == pll_seq_pkg::D_LOCK, s.l1.d_st == pll_seq_pkg::D_LOCK,
                    a2_lk, a1_lk, r1v | r2v};
            end else if (addr == pll_seq_pkg::ADDR_FILT1) begin
                next_s.rdata = {{16{s.l1.integ[15]}}, s.l1.integ};
            end else if (addr == pll_seq_pkg::ADDR_FILT2) begin
                next_s.rdata = {{16{s.l2.integ[15]}}, s.l2.integ};
            end else if (addr == pll_seq_pkg::ADDR_NUM1) begin
                next_s.rdata = {8'h00, s.l1.num};
            end else if (addr == pll_seq_pkg::ADDR_NUM2) begin
                next_s.rdata = {8'h00, s.l2.num};
            end else if (addr == pll_seq_pkg::ADDR_BUF) begin
                next_s.rdata = {24'h000000, s.bufc};
            end
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.ctrl <= pll_seq_pkg::CTRL_RESET;
            s.bufc <= pll_seq_pkg::BUF_RESET;
            s.l1.num <= pll_seq_pkg::CENTRE_NUM;
            s.l2.num <= pll_seq_pkg::CENTRE_NUM;
        end else begin
            s <= next_s;
        end
    end

    // Output registers; all outputs come from flip-flops.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            feedback_num1 <= pll_seq_pkg::CENTRE_NUM;
            feedback_num2 <= pll_seq_pkg::CENTRE_NUM;
            denominator_select1 <= 1'b0;
            denominator_select2 <= 1'b0;
            ref_from_cascade1 <= 1'b0;
            ref_from_cascade2 <= 1'b0;
            doubler_on1 <= 1'b0;
            doubler_on2 <= 1'b0;
            digital_loop_power1 <= 1'b0;
            digital_loop_power2 <= 1'b0;
            osc_buffer_switches <= '0;
            osc_monitor_clk_en <= 1'b0;
            rdata <= '0;
        end else begin
            // With digital loop two off, loop two just follows its divided source.
            feedback_num1 <= s.l1.num;
            feedback_num2 <= s.l2.num;
            denominator_select1 <= s.ctrl[pll_seq_pkg::CTRL_DENOM1];
            denominator_select2 <= s.ctrl[pll_seq_pkg::CTRL_DENOM2];
            // Downstream loop takes divided source clock, else oscillator input.
            ref_from_cascade1 <= s.ctrl[pll_seq_pkg::CTRL_CASCADE] &
                s.ctrl[pll_seq_pkg::CTRL_UPSTREAM2];
            ref_from_cascade2 <= s.ctrl[pll_seq_pkg::CTRL_CASCADE] &
                ~s.ctrl[pll_seq_pkg::CTRL_UPSTREAM2];
            doubler_on1 <= s.ctrl[pll_seq_pkg::CTRL_DBL1];
            doubler_on2 <= s.ctrl[pll_seq_pkg::CTRL_DBL2];
            digital_loop_power1 <= s.ctrl[pll_seq_pkg::CTRL_DLOOP1_ON];
            digital_loop_power2 <= s.ctrl[pll_seq_pkg::CTRL_DLOOP2_ON];
            osc_buffer_switches <= pll_seq_pkg::decode_buf(s.bufc);
            osc_monitor_clk_en <= osc_ok;
            rdata <= next_s.rdata;
        end
    end
endmodule // pll_cascade_startup_control
`default_nettype wire

// file: test/pll_seq_assertions.sv
`default_nettype none
module pll_seq_assertions (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic [23:0] feedback_num1,
    input wire logic denominator_select1,
    input wire logic denominator_select2,
    input wire logic ref_from_cascade1,
    input wire logic ref_from_cascade2,
    input wire logic doubler_on1,
    input wire logic doubler_on2,
    input wire logic digital_loop_power1,
    input wire logic digital_loop_power2,
    input wire logic [3:0] osc_buffer_switches
);
    logic [11:0] ctrl_q;
    logic [7:0] wcode;
    assign wcode = wdata[7:0];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Shadow of the control register, because the checker cannot look inside the block.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 12'h000;
        end else if (wr && addr == pll_seq_pkg::ADDR_CTRL) begin
            ctrl_q <= wdata[11:0];
        end
    end
    // Switches {single_ended, term50, term100, bias}; unlisted codes leave all off.
    function automatic logic [3:0] sw_of(input logic [7:0] c);
        case (c)
            8'h01: return 4'h1;
            8'h03: return 4'h3;
            8'h04: return 4'h4;
            8'h05: return 4'h5;
            8'h08: return 4'h8;
            8'h0c: return 4'hc;
            default: return 4'h0;
        endcase
    endfunction
    sequence s_buf_write;
        wr && addr == pll_seq_pkg::ADDR_BUF;
    endsequence
    // The code is looked up two samples back, where the write strobe stood.
    property p_buf_decode;
        s_buf_write |-> ##2 osc_buffer_switches == sw_of($past(wcode, 2));
    endproperty
    a_buf_decode: assert property (p_buf_decode)
        else $error("buffer switches do not match the code");
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_num_centre: assert property ($rose(rst_n) |-> feedback_num1 == 24'h800000)
        else $error("numerator not centred after reset");
    a_denom_sel: assert property ({denominator_select2, denominator_select1}
        == $past(ctrl_q[9:8])) else $error("denominator select wrong");
    a_doubler_en: assert property ({doubler_on2, doubler_on1} == $past(ctrl_q[11:10]))
        else $error("doubler enable wrong");
    a_noncascade_ref: assert property (!$past(ctrl_q[4]) |->
        !ref_from_cascade1 && !ref_from_cascade2) else $error("cascade ref while not cascaded");
    a_cascade_dir: assert property ($past(ctrl_q[4]) |-> ref_from_cascade1 == $past(ctrl_q[5])
        && ref_from_cascade2 != $past(ctrl_q[5])) else $error("cascade direction wrong");
    a_dloop_off: assert property (!$past(ctrl_q[2]) |-> !digital_loop_power1)
        else $error("digital loop one powered while disabled");
    a_dloop2_off: assert property (!$past(ctrl_q[3]) |-> !digital_loop_power2)
        else $error("digital loop two powered while disabled");
endmodule // pll_seq_assertions
bind pll_cascade_startup_control pll_seq_assertions chk (.core_clk, .rst_n, .addr, .wdata,
    .wr, .rd, .rdata, .feedback_num1, .denominator_select1, .denominator_select2,
    .ref_from_cascade1, .ref_from_cascade2, .doubler_on1, .doubler_on2,
    .digital_loop_power1, .digital_loop_power2, .osc_buffer_switches);
`default_nettype wire

// file: test/ref_side_model.sv
`default_nettype none
module ref_side_model #(
    // Targets sit off the centre numerator, so each feedback ratio stays fractional.
    parameter logic [23:0] TARGET1 = 24'h7ffedd,
    parameter logic [23:0] TARGET2 = 24'h800040
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ref1_on,
    input wire logic ref2_on,
    input wire logic osc_on,
    input wire logic [23:0] feedback_num1,
    input wire logic [23:0] feedback_num2,
    output logic ref1_valid_pin,
    output logic ref2_valid_pin,
    output logic ref_osc_present_pin,
    output logic signed [15:0] phase_err1,
    output logic signed [15:0] phase_err2,
    output logic phase_stb1,
    output logic phase_stb2
);
    logic [3:0] tick;
    // Phase error seen by the comparator: feedback ahead of the reference is positive.
    function automatic logic signed [15:0] sat(input logic [23:0] n, input logic [23:0] t);
        logic signed [24:0] d;
        d = $signed({1'b0, n}) - $signed({1'b0, t});
        if (d > 25'sd32767) return 16'sh7fff;
        if (d < -25'sd32768) return 16'sh8000;
        return d[15:0];
    endfunction
    // Reference qualifiers and the oscillator come straight from the bench.
    assign ref1_valid_pin = ref1_on;
    assign ref2_valid_pin = ref2_on;
    assign ref_osc_present_pin = osc_on;
    // One word every 16 cycles; between words the bus toggles so stale data never looks valid.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 4'h0;
            phase_stb1 <= 1'b0;
            phase_stb2 <= 1'b0;
            phase_err1 <= 16'sh0;
            phase_err2 <= 16'sh0;
        end else begin
            tick <= tick + 4'h1;
            phase_stb1 <= (tick == 4'hf);
            phase_stb2 <= (tick == 4'h7);
            phase_err1 <= (tick == 4'hf) ? sat(feedback_num1, TARGET1) : ~phase_err1;
            phase_err2 <= (tick == 4'h7) ? sat(feedback_num2, TARGET2) : ~phase_err2;
        end
    end
endmodule // ref_side_model
`default_nettype wire

// file: test/pll_cascade_startup_control_test.sv
`default_nettype none
module pll_cascade_startup_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] CENTRE = 24'h800000;
    localparam logic [23:0] TGT1 = 24'h7ffedd;
    localparam logic [23:0] TGT2 = 24'h800040;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ref1_on = 1'b0;
    logic ref2_on = 1'b0;
    logic osc_on = 1'b0;
    logic [31:0] rdata, d, v;
    logic v1, v2, op, s1, s2, den1, den2, cas1, cas2, dbl1, dbl2, dp1, dp2, mon;
    logic signed [15:0] e1, e2;
    logic [23:0] num1, num2;
    logic [3:0] sw;
    int err_count = 0;
    int n_tests = 0;
    int i;
    `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
        $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
    // Free-running 100 MHz clock.
    always #5 core_clk = ~core_clk;
    ref_side_model far (.core_clk, .rst_n, .ref1_on, .ref2_on, .osc_on,
        .feedback_num1(num1), .feedback_num2(num2), .ref1_valid_pin(v1), .ref2_valid_pin(v2),
        .ref_osc_present_pin(op), .phase_err1(e1), .phase_err2(e2), .phase_stb1(s1),
        .phase_stb2(s2));
    pll_cascade_startup_control uut (.core_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
        .ref1_valid_pin(v1), .ref2_valid_pin(v2), .ref_osc_present_pin(op),
        .phase_err1(e1), .phase_err2(e2), .phase_stb1(s1), .phase_stb2(s2),
        .feedback_num1(num1), .feedback_num2(num2), .denominator_select1(den1),
        .denominator_select2(den2), .ref_from_cascade1(cas1), .ref_from_cascade2(cas2),
        .doubler_on1(dbl1), .doubler_on2(dbl2), .digital_loop_power1(dp1),
        .digital_loop_power2(dp2), .osc_buffer_switches(sw), .osc_monitor_clk_en(mon));
    // Expected switches {single_ended, term50, term100, bias}.
    function automatic logic [3:0] bsw(input logic [7:0] c);
        case (c)
            8'h01: return 4'h1;
            8'h03: return 4'h3;
            8'h04: return 4'h4;
            8'h05: return 4'h5;
            8'h08: return 4'h8;
            8'h0c: return 4'hc;
            default: return 4'h0;
        endcase
    endfunction
    // Bus cycles: signals change just after an edge and stay for exactly one cycle.
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] val);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= val;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] val);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        val = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Polls status until every bit of the mask is set; running out counts as a mismatch.
    task automatic wait_st(input logic [5:0] m);
        for (i = 0; i < 1500; i++) begin
            rd_reg(pll_seq_pkg::ADDR_STATUS, d);
            if ((d[5:0] & m) === m) break;
        end
        `CHK(d[5:0] & m, m)
        if (i == 1500) conclude();
    endtask
    initial begin
        void'($urandom(68695));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        settle(1);
        `CHK(num1, CENTRE)
        `CHK({den1, den2, cas1, cas2, dbl1, dbl2, dp1, dp2, sw, mon}, 13'h0000)
        rd_reg(pll_seq_pkg::ADDR_CTRL, d);
        `CHK(d, 32'h0)
        rd_reg(4'hf, d);
        `CHK(d, 32'h0)
        $display("reset test done");
        for (int k = 0; k < 14; k++) begin
            v = (k < 7) ? {24'h0, 8'(56'h0001030405080c >> (48 - 8 * k))}
                : {24'h0, 8'($urandom)};
            wr_reg(pll_seq_pkg::ADDR_BUF, {24'h0, v[7:0]});
            settle(2);
            `CHK(sw, bsw(v[7:0]))
        end
        for (int k = 0; k < 8; k++) begin
            v = (k == 0) ? 32'hf00 : ($urandom & 32'hf00);
            // A 40-bit denominator only ever comes with its digital loop on.
            v = v | {28'h0, v[9:8], 2'b00};
            wr_reg(pll_seq_pkg::ADDR_CTRL, v);
            settle(2);
            `CHK({den2, den1}, v[9:8])
            `CHK({dbl2, dbl1}, v[11:10])
        end
        $display("buffer and control test done");
        // Independent loops, loop one ordered behind loop two.
        osc_on <= 1'b1;
        wr_reg(pll_seq_pkg::ADDR_CTRL, 32'h043);
        wait_st(6'h04);
        `CHK(d[1], 1'b0)
        `CHK({cas1, cas2}, 2'b00)
        `CHK(mon, 1'b1)
        wait_st(6'h06);
        `CHK(num1, CENTRE)
        $display("start order test done");
        // Digital loop one waits for a qualified reference, then corrects once directly.
        wr_reg(pll_seq_pkg::ADDR_CTRL, 32'h047);
        settle(300);
        `CHK(num1, CENTRE)
        ref1_on <= 1'b1;
        settle(900);
        `CHK(num1, CENTRE)
        `CHK(dp1, 1'b1)
        for (i = 0; i < 600 && num1 === CENTRE; i++) settle(1);
        `CHK(num1, TGT1)
        wait_st(6'h08);
        `CHK(num1, TGT1)
        `CHK(num2, CENTRE)
        $display("digital loop test done");
        // Host recalibration of loop two by cycling its power bit.
        wr_reg(pll_seq_pkg::ADDR_CTRL, 32'h045);
        rd_reg(pll_seq_pkg::ADDR_STATUS, d);
        rd_reg(pll_seq_pkg::ADDR_STATUS, d);
        `CHK(d[2], 1'b0)
        wr_reg(pll_seq_pkg::ADDR_CTRL, 32'h0c7);
        wait_st(6'h04);
        $display("recalibration test done");
        // Digital loop two steers its own numerator while loop one stays locked.
        ref2_on <= 1'b1;
        wr_reg(pll_seq_pkg::ADDR_CTRL, 32'h0cf);
        wait_st(6'h18);
        `CHK(num2, TGT2)
        `CHK(num1, TGT1)
        $display("digital loop two test done");
        // Cascade both ways, reset between; digital references never use an oscillator.
        wr_reg(pll_seq_pkg::ADDR_CTRL, 32'h010);
        wr_reg(pll_seq_pkg::ADDR_CTRL, 32'h013);
        settle(2);
        `CHK({cas1, cas2, dp1, dp2}, 4'b0100)
        wait_st(6'h04);
        `CHK(d[1], 1'b0)
        wait_st(6'h06);
        rst_n <= 1'b0;
        settle(3);
        rst_n <= 1'b1;
        settle(1);
        `CHK({num1, cas1, cas2}, {CENTRE, 2'b00})
        wr_reg(pll_seq_pkg::ADDR_CTRL, 32'h033);
        settle(2);
        `CHK({cas1, cas2}, 2'b10)
        wait_st(6'h02);
        `CHK(d[2], 1'b0)
        wait_st(6'h06);
        $display("cascade test done");
        conclude();
    end
endmodule // pll_cascade_startup_control_test
`default_nettype wire
